// [rtl/ctsf_pkg.sv]
// package for the transmit select and filter control block
package ctsf_pkg;
  localparam logic [7:0] ADDR_ABORT_ACK = 8'h00;
  localparam logic [7:0] ADDR_TX_SEL    = 8'h04;
  localparam logic [7:0] ADDR_FILT_CTL  = 8'h08;
  localparam logic [7:0] ADDR_RESERVED  = 8'h0C;
  localparam logic [7:0] ADDR_TX_EMPTY  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
  localparam logic [7:0] ADDR_INIT_CTL  = 8'h1C;
  localparam int         NBUF           = 3;
  localparam int         MODE_LSB       = 4;
  localparam logic [2:0] BUF_RST        = 3'h0;
  localparam logic [1:0] MODE_RST       = 2'h0;
  localparam logic [2:0] HIT_RST        = 3'h0;
  localparam logic [2:0] TXE_RST        = 3'h7;
  localparam logic [1:0] MODE_TWO32     = 2'h0;
  localparam logic [1:0] MODE_FOUR16    = 2'h1;
  localparam logic [1:0] MODE_EIGHT8    = 2'h2;
  localparam logic [1:0] MODE_CLOSED    = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;
  // irq status layout: [2:0] abort done, [5:3] transmit done, [6] message accepted
  localparam int         IRQ_W          = 7;
  localparam int         IRQ_TXD_LSB    = 3;
  localparam int         IRQ_RX_BIT     = 6;
endpackage

// [rtl/ctsf_top.sv]
// transmit abort ack, buffer selection, acceptance control and reserved registers
// Overview of operation
// - abort ack held reset during init
// - abort ack bit set on aborted message
// - clearing empty flag clears abort ack
// - selector read shows lowest set bit
// - lowest set bit picks window buffer
// - window blocked for scheduled selected buffer
// - no selection blocks every window access
// - selector reset in init, writable outside
// - filter control writable only in init
// - organisation field decodes filter layout
// - closed filter accepts no message
// - match index reports filter number
// - index updated when foreground reloads
// - reserved register reads zero, ignores writes
// - empty flag set on send or abort
// - abort sets empty, ack and interrupt
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
module ctsf_top
  import ctsf_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic        I_HREADY,
  input  wire logic [31:0] I_HWDATA,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic [2:0]  I_TX_SENT,
  input  wire logic [2:0]  I_TX_ABORTED,
  input  wire logic        I_RX_SHIFT,
  input  wire logic        I_RX_MATCH,
  input  wire logic [2:0]  I_RX_HIT,
  input  wire logic        I_WIN_ACCESS,
  output logic      [2:0]  O_WIN_BUF,
  output logic             O_WIN_GRANT,
  output logic      [2:0]  O_ABORT_REQ,
  output logic      [2:0]  O_TX_EMPTY,
  output logic             O_RX_LOAD,
  output logic      [1:0]  O_FILT_MODE,
  output logic             O_INIT_ACK,
  output logic             O_IRQ
);

  typedef struct packed {
    logic             wr_pend;
    logic [7:0]       addr;
    logic             init_req;
    logic             init_ack;
    logic [NBUF-1:0]  transmit_empty_flags;
    logic [NBUF-1:0]  abt_req;
    logic [NBUF-1:0]  abt_ack;
    logic [NBUF-1:0]  sel;
    logic [1:0]       mode;
    logic [2:0]       hit;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic [31:0]      rdata;
  } ctsf_state_s;

  ctsf_state_s st_r;
  ctsf_state_s st_nxt;

  function automatic logic [NBUF-1:0] lowest_bit(input logic [NBUF-1:0] v);
    return v & (~v + NBUF'(1));
  endfunction

  logic            acc;
  logic            in_init;
  logic            out_init;
  logic [7:0]      wbyte;
  logic [NBUF-1:0] sel_low;
  logic [NBUF-1:0] txe_clr;
  logic [NBUF-1:0] txe_set;
  logic            rx_load;

  assign acc      = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
  assign in_init  = st_r.init_req && st_r.init_ack;
  assign out_init = !st_r.init_req && !st_r.init_ack;
  assign wbyte    = I_HWDATA[7:0];
  assign sel_low  = lowest_bit(st_r.sel);
  assign txe_set  = I_TX_SENT | I_TX_ABORTED;
  // a one written clears a flag; a set in the same cycle wins
  assign txe_clr  = (st_r.wr_pend && st_r.addr == ADDR_TX_EMPTY && out_init)
                    ? wbyte[NBUF-1:0] : '0;
  assign rx_load  = I_RX_SHIFT && I_RX_MATCH && (st_r.mode != MODE_CLOSED);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.wr_pend = acc && I_HWRITE && (I_HSIZE == HSIZE_WORD);
    st_nxt.addr    = I_HADDR[7:0];
    // init handshake: acknowledge follows request a cycle later
    st_nxt.init_ack = st_r.init_req;
    if (st_r.wr_pend) begin
      case (st_r.addr)
        ADDR_TX_SEL: begin
          if (out_init) st_nxt.sel = wbyte[NBUF-1:0];
        end
        ADDR_FILT_CTL: begin
          if (in_init) st_nxt.mode = wbyte[MODE_LSB+:2];
        end
        ADDR_IRQ_MASK: st_nxt.imask = wbyte[IRQ_W-1:0];
        ADDR_INIT_CTL: st_nxt.init_req = wbyte[0];
        ADDR_TX_EMPTY: begin
          if (out_init) st_nxt.abt_req = st_r.abt_req | (wbyte[7:4] == 4'h0 ? '0 : wbyte[6:4]);
        end
        default: ;
      endcase
    end
    st_nxt.transmit_empty_flags     = (st_r.transmit_empty_flags & ~txe_clr) | txe_set;
    // a request only lives while its buffer is scheduled
    st_nxt.abt_req = st_nxt.abt_req & ~txe_set & ~st_r.transmit_empty_flags;
    st_nxt.abt_ack = (st_r.abt_ack & ~txe_clr & ~I_TX_SENT) | I_TX_ABORTED;
    if (rx_load) st_nxt.hit = I_RX_HIT;
    // read data captured in address phase; irq status read clears
    st_nxt.rdata = '0;
    if (acc && !I_HWRITE) begin
      case (I_HADDR[7:0])
        ADDR_ABORT_ACK: st_nxt.rdata[NBUF-1:0] = st_r.abt_ack;
        ADDR_TX_SEL:    st_nxt.rdata[NBUF-1:0] = sel_low;
        ADDR_FILT_CTL: begin
          st_nxt.rdata[MODE_LSB+:2] = st_r.mode;
          st_nxt.rdata[2:0]         = st_r.hit;
        end
        ADDR_RESERVED:  st_nxt.rdata = '0;
        ADDR_TX_EMPTY: begin
          st_nxt.rdata[NBUF-1:0] = st_r.transmit_empty_flags;
          st_nxt.rdata[6:4]      = st_r.abt_req;
        end
        ADDR_IRQ_STAT:  st_nxt.rdata[IRQ_W-1:0] = st_r.ist;
        ADDR_IRQ_MASK:  st_nxt.rdata[IRQ_W-1:0] = st_r.imask;
        ADDR_INIT_CTL: begin
          st_nxt.rdata[0] = st_r.init_req;
          st_nxt.rdata[1] = st_r.init_ack;
        end
        default: st_nxt.rdata = '0;
      endcase
    end
    if (acc && !I_HWRITE && I_HADDR[7:0] == ADDR_IRQ_STAT) st_nxt.ist = '0;
    st_nxt.ist = st_nxt.ist
               | {rx_load, I_TX_SENT, I_TX_ABORTED};
    if (in_init) begin
      st_nxt.abt_ack = BUF_RST;
      st_nxt.sel     = BUF_RST;
      st_nxt.abt_req = BUF_RST;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_r.wr_pend  <= 1'b0;
      st_r.addr     <= 8'h00;
      st_r.init_req <= 1'b1;
      st_r.init_ack <= 1'b0;
      st_r.transmit_empty_flags      <= TXE_RST;
      st_r.abt_req  <= BUF_RST;
      st_r.abt_ack  <= BUF_RST;
      st_r.sel      <= BUF_RST;
      st_r.mode     <= MODE_RST;
      st_r.hit      <= HIT_RST;
      st_r.ist      <= '0;
      st_r.imask    <= '0;
      st_r.rdata    <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_HRDATA    = st_r.rdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign O_WIN_BUF   = sel_low;
  // refused if nothing selected or the selected buffer is scheduled
  assign O_WIN_GRANT = I_WIN_ACCESS && (sel_low != '0)
                       && ((sel_low & ~st_r.transmit_empty_flags) == '0);
  assign O_ABORT_REQ = st_r.abt_req;
  assign O_TX_EMPTY  = st_r.transmit_empty_flags;
  assign O_RX_LOAD   = rx_load;
  assign O_FILT_MODE = st_r.mode;
  assign O_INIT_ACK  = st_r.init_ack;
  assign O_IRQ       = |(st_r.ist & st_r.imask);

  a_ack_init: assert property (@(posedge I_CLK) disable iff (I_RST)
    in_init |=> st_r.abt_ack == BUF_RST) else $error("abort ack not held in init");
  a_ack_abort: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_TX_ABORTED[0] && !in_init) |=> st_r.abt_ack[0]) else $error("abort ack not set");
  a_ack_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    (txe_clr[1] && !I_TX_ABORTED[1]) |=> !st_r.abt_ack[1]) else $error("ack not cleared");
  a_sel_read: assert property (@(posedge I_CLK) disable iff (I_RST)
    $countones(sel_low) <= 1 && ((st_r.sel == '0) == (sel_low == '0)))
    else $error("selector read not lowest bit");
  a_win_block: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sel_low == '0 || (sel_low & ~st_r.transmit_empty_flags) != '0) |-> !O_WIN_GRANT)
    else $error("window access not blocked");
  a_sel_init: assert property (@(posedge I_CLK) disable iff (I_RST)
    in_init |=> st_r.sel == BUF_RST) else $error("selector not held in init");
  a_mode_lock: assert property (@(posedge I_CLK) disable iff (I_RST)
    !in_init |=> $stable(st_r.mode)) else $error("filter mode changed outside init");
  a_closed_load: assert property (@(posedge I_CLK) disable iff (I_RST)
    st_r.mode == MODE_CLOSED |-> !O_RX_LOAD) else $error("closed filter loaded");
  a_hit_track: assert property (@(posedge I_CLK) disable iff (I_RST)
    rx_load |=> st_r.hit == $past(I_RX_HIT)) else $error("match index not updated");
  a_txe_set: assert property (@(posedge I_CLK) disable iff (I_RST)
    txe_set[2] |=> st_r.transmit_empty_flags[2]) else $error("empty flag not set");

endmodule

// [sim/ctsf_far_model.sv]
// far side model: transmit outcomes and receive shifts
module ctsf_far_model (
  input  wire logic       i_clk,
  output logic      [2:0] o_sent,
  output logic      [2:0] o_aborted,
  output logic            o_shift,
  output logic            o_match,
  output logic      [2:0] o_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sent = 3'h0;
    o_aborted = 3'h0;
    o_shift = 1'b0;
    o_match = 1'b0;
    o_hit = 3'h0;
  end
  // one-cycle outcome pulse, abort or sent
  task automatic tx_done(input logic ab, input logic [2:0] b);
    @(posedge i_clk);
    if (ab) o_aborted <= b;
    else o_sent <= b;
    @(posedge i_clk);
    o_aborted <= 3'h0;
    o_sent <= 3'h0;
  endtask
  // qualifiers flip after the shift so stale values never match by luck
  task automatic rx(input logic m, input logic [2:0] h);
    @(posedge i_clk);
    o_shift <= 1'b1;
    o_match <= m;
    o_hit <= h;
    @(posedge i_clk);
    o_shift <= 1'b0;
    o_match <= ~m;
    o_hit <= ~h;
  endtask
endmodule

// [sim/tb.sv]
// register-level testbench for the select and filter block
module tb;
  import ctsf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, win = 1;
  int n_load = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic hready, hresp, rx_load, init_ack, irq, shift, match, grant;
  logic [2:0] sent, abrt, hit, wbuf, abreq, transmit_empty_flags;
  logic [1:0] fmode;
  int err_total = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  ctsf_top ctsf_top_inst (.I_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(HSIZE_WORD), .I_HREADY(hready),
    .I_HWDATA(hwdata), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_TX_SENT(sent), .I_TX_ABORTED(abrt), .I_RX_SHIFT(shift), .I_RX_MATCH(match),
    .I_RX_HIT(hit), .I_WIN_ACCESS(win), .O_WIN_BUF(wbuf), .O_WIN_GRANT(grant),
    .O_ABORT_REQ(abreq), .O_TX_EMPTY(transmit_empty_flags), .O_RX_LOAD(rx_load), .O_FILT_MODE(fmode),
    .O_INIT_ACK(init_ack), .O_IRQ(irq));
  ctsf_far_model ctsf_far_model_inst (.i_clk(clk), .o_sent(sent), .o_aborted(abrt),
    .o_shift(shift), .o_match(match), .o_hit(hit));
  always @(posedge clk) if (rx_load === 1'b1) n_load <= n_load + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hold address phase until ready, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // acknowledge follows the request one cycle later
  task automatic init(input logic r);
    bus(1'b1, ADDR_INIT_CTL, {31'h0, r});
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(init_ack, 1);
    chk(hresp, 0);
    rd(ADDR_ABORT_ACK, 0);
    rd(ADDR_TX_EMPTY, 32'h7);
    bus(1'b1, ADDR_RESERVED, 32'hFF);
    rd(ADDR_RESERVED, 0);
    rd(8'h20, 0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h7F);
    bus(1'b1, ADDR_TX_SEL, 32'h6);
    rd(ADDR_TX_SEL, 0);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADDR_FILT_CTL, {26'h0, m[1:0], 4'hF});
      rd(ADDR_FILT_CTL, {26'h0, m[1:0], 4'h0});
      chk(fmode, m[1:0]);
    end
    init(1'b0);
    far_rx(1'b1, 3'h5);
    chk(n_load, 0);
    rd(ADDR_FILT_CTL, 32'h30);
    init(1'b1);
    bus(1'b1, ADDR_FILT_CTL, 32'h10);
    init(1'b0);
    far_rx(1'b1, 3'h5);
    chk(n_load, 1);
    rd(ADDR_FILT_CTL, 32'h15);
    bus(1'b1, ADDR_FILT_CTL, 32'h20);
    rd(ADDR_FILT_CTL, 32'h15);
    bus(1'b1, ADDR_TX_EMPTY, 32'h1);
    bus(1'b0, ADDR_TX_EMPTY, 32'h0);
    bus(1'b1, ADDR_TX_SEL, q);
    rd(ADDR_TX_SEL, 32'h2);
    chk(wbuf, 3'h2);
    chk(grant, 1);
    bus(1'b1, ADDR_TX_SEL, 32'h3);
    rd(ADDR_TX_SEL, 32'h1);
    chk(grant, 0);
    bus(1'b1, ADDR_TX_SEL, 32'h0);
    chk(grant, 0);
    bus(1'b1, ADDR_TX_EMPTY, 32'h10);
    chk(abreq, 3'h1);
    ctsf_far_model_inst.tx_done(1'b1, 3'h1);
    #1;
    chk(transmit_empty_flags, 3'h7);
    chk(abreq, 3'h0);
    chk(irq, 1);
    rd(ADDR_ABORT_ACK, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h41);
    chk(irq, 0);
    bus(1'b1, ADDR_TX_EMPTY, 32'h1);
    rd(ADDR_ABORT_ACK, 32'h0);
    ctsf_far_model_inst.tx_done(1'b0, 3'h1);
    #1;
    chk(transmit_empty_flags, 3'h7);
    rd(ADDR_ABORT_ACK, 32'h0);
    // masked events stay visible in status without raising the line
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    ctsf_far_model_inst.tx_done(1'b0, 3'h4);
    #1;
    chk(irq, 0);
    rd(ADDR_IRQ_STAT, 32'h28);
    bus(1'b1, ADDR_TX_EMPTY, 32'h2);
    bus(1'b1, ADDR_TX_EMPTY, 32'h20);
    ctsf_far_model_inst.tx_done(1'b1, 3'h2);
    rd(ADDR_ABORT_ACK, 32'h2);
    init(1'b1);
    rd(ADDR_ABORT_ACK, 32'h0);
    give_verdict;
  end
  task automatic far_rx(input logic m, input logic [2:0] h);
    ctsf_far_model_inst.rx(m, h);
    #1;
  endtask
endmodule
